/* verilog/dsam_pkg.sv */
// Constants and types for the disc sector address match block.
// Assumes a single 50 MHz controller clock.
package dsam_pkg;
   localparam int          CLK_PERIOD_NS  = 20;
   localparam int          SUB_W          = 4;
   localparam int          SEC_W          = 5;
   localparam int          TRK_W          = 7;
   localparam int          UNIT_W         = 2;
   localparam int          LOC_W          = 12;
   localparam int          HDATA_W        = 16;
   localparam int          TRKLINE_W      = 9;
   localparam int          SUB_LSB        = 0;
   localparam int          UNIT_LSB       = 2;
   localparam int          TRK_LSB        = 4;
   localparam int          SEC_LSB        = 11;
   localparam logic [3:0]  SUB_LAST       = 4'hF;
   localparam logic [4:0]  SEC_LAST       = 5'h1F;
   localparam logic [6:0]  TRK_LAST       = 7'h7F;
   localparam logic [8:0]  TRK_MAX_RST    = 9'h07F;
   localparam logic [4:0]  XFER_SUBS      = 5'h10;
   localparam logic [1:0]  ILV_RST        = 2'h0;
   localparam logic [11:0] LOC_RST        = 12'h000;
   localparam logic [11:0] A_CTRL         = 12'h000;
   localparam logic [11:0] A_ADDR         = 12'h004;
   localparam logic [11:0] A_LOC          = 12'h008;
   localparam logic [11:0] A_STAT         = 12'h00C;
   localparam logic [11:0] A_TRKMAX       = 12'h010;

   typedef enum {ST_IDLE, ST_XFER} dsam_state_type;

   // Interlace spreads sector bits: counter bits chosen by shift
   function automatic logic [8:0] ilv_pick(input logic [LOC_W-1:0] loc,
                                           input logic [1:0]       f);
      logic [LOC_W-1:0] s;
      s = loc >> f;
      ilv_pick = {s[8:4], loc[3:0]};
   endfunction
endpackage

/* verilog/dsam_sync_if.sv */
// Interface carrying the synchronised drive levels and their edges.
// Assumes one producer (the synchroniser) and one consumer (the core).
`timescale 1ns/1ns
interface dsam_sync_if;
   logic origin;
   logic origin_rise;
   logic origin_fall;
   logic ssync_rise;
   logic ready;
   logic ready_fall;
   modport src (output origin, origin_rise, origin_fall, ssync_rise, ready, ready_fall);
   modport dst (input origin, origin_rise, origin_fall, ssync_rise, ready, ready_fall);
endinterface

/* verilog/dsam_sync.sv */
// Two-stage synchronisers and edge detectors for the drive inputs.
// Assumes drive signals are asynchronous to pclk.
`timescale 1ns/1ns
module dsam_sync
   import dsam_pkg::*;
(
   // Clock and reset
   input  wire logic   pclk,
   input  wire logic   presetn,
   // Drive inputs
   input  wire logic   track_origin,
   input  wire logic   subsector_sync_n,
   input  wire logic   disc_ready,
   // Conditioned outputs
   dsam_sync_if.src    so
);
   logic [2:0] meta_r;
   logic [2:0] stab_r;
   logic [2:0] last_r;

   // Stage one feeds stage two only; edges come from stages two and three
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta_r <= 3'h2;
         stab_r <= 3'h2;
         last_r <= 3'h2;
      end
      else
      begin
         meta_r <= {disc_ready, subsector_sync_n, track_origin};
         stab_r <= meta_r;
         last_r <= stab_r;
      end
   end

   assign so.origin      = stab_r[0];
   assign so.origin_rise = stab_r[0] & ~last_r[0];
   assign so.origin_fall = ~stab_r[0] & last_r[0];
   assign so.ssync_rise  = stab_r[1] & ~last_r[1];
   assign so.ready       = stab_r[2];
   assign so.ready_fall  = ~stab_r[2] & last_r[2];
endmodule

/* verilog/dsam_top.sv */
// Track, sector and subsector addressing with rotational match.
// Assumes host strobes are one-cycle pulses synchronous to pclk;
// drive signals arrive asynchronously and are synchronised here.
//
// What this block does
// - Step subsector counter when parity cycle ends
// - Last sector sets pending; track steps at origin
// - Head switch request on advance, load, reset
// - Default transfer length is sixteen subsectors
// - Track taken from host bits four to ten
// - Track 127 wrap at origin fall clears enable
// - Track address driven continuously to drive
// - Unit steps when track at max and origin
// - Twelve-bit location counter cleared at origin
// - Location counts on subsector sync rising edge
// - 32 sectors of 16 subsectors per track
// - Subsector bits 0-3, sector bits 11-15
// - Compare through interlace bit selection
// - Sector equal both polarities when enabled
// - Enable set on track origin rising
// - Enable cleared by not ready, unit change, reset
// - Wait one origin period after unit change
// - Subsector register loads on its command; address load clears it
`timescale 1ns/1ns
module dsam_top
   import dsam_pkg::*;
(
   // Clock and reset
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   // APB slave
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [11:0]          paddr,
   input  wire logic [31:0]          pwdata,
   output      logic [31:0]          prdata,
   output      logic                 pready,
   output      logic                 pslverr,
   // Host adapter strobes
   input  wire logic                 address_output_strobe,
   input  wire logic                 load_subsector_command,
   input  wire logic [HDATA_W-1:0]   host_data_bit,
   // Controller
   input  wire logic                 parity_cycle_flag,
   // Drive
   input  wire logic                 track_origin,
   input  wire logic                 subsector_sync_n,
   input  wire logic                 disc_ready,
   output      logic [TRKLINE_W-1:0] track_addr_line,
   output      logic [UNIT_W-1:0]    unit_addr,
   output      logic                 head_switch_request_n,
   output      logic                 sector_equal,
   output      logic                 sector_equal_n,
   output      logic                 xfer_done
);

   dsam_sync_if sy ();

   dsam_sync u_sync
   (
      .pclk             (pclk),
      .presetn          (presetn),
      .track_origin     (track_origin),
      .subsector_sync_n (subsector_sync_n),
      .disc_ready       (disc_ready),
      .so               (sy)
   );

   logic [SUB_W-1:0]  sub_r;
   logic [SEC_W-1:0]  sec_r;
   logic [TRK_W-1:0]  trk_r;
   logic [UNIT_W-1:0] unit_r;
   logic [LOC_W-1:0]  loc_r;
   logic [1:0]        ilv_r;
   logic [8:0]        trkmax_r;
   logic              pend_r;
   logic              wrap_arm_r;
   logic              seq_en_r;
   logic              sub_mode_r;
   logic              pty_last_r;
   logic [4:0]        xcnt_r;
   logic              ucg_r;
   dsam_state_type    st_r;

   logic              apb_wr;
   logic              apb_rd;
   logic              load;
   logic              sub_step;
   logic              sec_carry;
   logic              trk_step;
   logic              unit_step;
   logic              match;
   logic [UNIT_W-1:0] unit_nxt;

   // Register writes land at the access phase only
   assign apb_wr    = psel & penable & pwrite;
   assign apb_rd    = psel & ~penable & ~pwrite;
   assign load      = address_output_strobe;
   assign sub_step  = pty_last_r & ~parity_cycle_flag;
   assign sec_carry = sub_step & (sub_r == SUB_LAST);
   assign trk_step  = pend_r & sy.origin_rise;
   assign unit_step = trk_step & ({2'h0, trk_r} >= trkmax_r[8:0]);

   assign match = (({sec_r, sub_r} ^ ilv_pick(loc_r, ilv_r))
                   & {5'h1F, {SUB_W{sub_mode_r}}}) == 9'h000;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pty_last_r <= 1'b0;
      else
         pty_last_r <= parity_cycle_flag;
   end

   // Subsector and sector address counters
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sub_r      <= 4'h0;
         sec_r      <= 5'h00;
         sub_mode_r <= 1'b0;
      end
      else if (load_subsector_command)
      begin
         sub_r      <= host_data_bit[SUB_LSB +: SUB_W];
         sub_mode_r <= 1'b1;
      end
      else if (load)
      begin
         sec_r      <= host_data_bit[SEC_LSB +: SEC_W];
         sub_r      <= 4'h0;
         sub_mode_r <= 1'b0;
      end
      else if (sub_step)
      begin
         sub_r <= sub_r + 4'h1;
         if (sec_carry)
            sec_r <= sec_r + 5'h01;
      end
   end

   // Pending track advance: set at last sector, cleared on origin fall
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pend_r <= 1'b0;
      else if (sec_carry && sec_r == SEC_LAST)
         pend_r <= 1'b1;
      else if (sy.origin_fall)
         pend_r <= 1'b0;
   end

   // Track and unit counters
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         trk_r  <= 7'h00;
         unit_r <= 2'h0;
      end
      else if (load)
      begin
         trk_r  <= host_data_bit[TRK_LSB +: TRK_W];
         unit_r <= host_data_bit[UNIT_LSB +: UNIT_W];
      end
      else if (unit_step)
      begin
         trk_r  <= 7'h00;
         unit_r <= unit_r + 2'h1;
      end
      else if (trk_step)
         trk_r <= trk_r + 7'h01;
   end

   assign unit_nxt = load ? host_data_bit[UNIT_LSB +: UNIT_W] :
                     unit_step ? unit_r + 2'h1 : unit_r;

   // Unit change pulse whenever the selected unit differs
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ucg_r <= 1'b0;
      else
         ucg_r <= (unit_nxt != unit_r);
   end

   // Wrap arm: set while track is 127 and origin high, cleared as origin falls
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         wrap_arm_r <= 1'b0;
      else if (sy.origin_fall)
         wrap_arm_r <= 1'b0;
      else if (trk_r == TRK_LAST && sy.origin)
         wrap_arm_r <= 1'b1;
   end

   // Enable: clear wins; after unit change it waits for an origin rise
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         seq_en_r <= 1'b0;
      else if (sy.ready_fall || !sy.ready || ucg_r)
         seq_en_r <= 1'b0;
      else if (wrap_arm_r && sy.origin_fall)
         seq_en_r <= 1'b0;
      else if (sy.origin_rise)
         seq_en_r <= 1'b1;
   end

   // Location counter, held clear while origin asserted
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         loc_r <= LOC_RST;
      else if (sy.origin)
         loc_r <= LOC_RST;
      else if (sy.ssync_rise)
         loc_r <= loc_r + 12'h001;
   end

   // Sector equal outputs, both polarities
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sector_equal   <= 1'b0;
         sector_equal_n <= 1'b1;
      end
      else
      begin
         sector_equal   <= match & seq_en_r;
         sector_equal_n <= ~(match & seq_en_r);
      end
   end

   // Head switch request and track lines
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         head_switch_request_n <= 1'b0;
         track_addr_line       <= 9'h000;
         unit_addr             <= 2'h0;
      end
      else
      begin
         head_switch_request_n <= ~(trk_step | load);
         track_addr_line       <= {2'h0, trk_r};
         unit_addr             <= unit_r;
      end
   end

   // Transfer length: one sector unless subsector mode
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_r      <= ST_IDLE;
         xcnt_r    <= 5'h00;
         xfer_done <= 1'b0;
      end
      else
      begin
         xfer_done <= 1'b0;
         case (st_r)
            ST_IDLE:
               if (load)
               begin
                  st_r   <= ST_XFER;
                  xcnt_r <= 5'h00;
               end
            ST_XFER:
               if (load)
                  xcnt_r <= 5'h00;
               else if (sub_step && !sub_mode_r)
               begin
                  xcnt_r <= xcnt_r + 5'h01;
                  if (xcnt_r + 5'h01 == XFER_SUBS)
                  begin
                     xfer_done <= 1'b1;
                     st_r      <= ST_IDLE;
                  end
               end
            default:
               st_r <= ST_IDLE;
         endcase
      end
   end

   // APB configuration: interlace and track maximum
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ilv_r    <= ILV_RST;
         trkmax_r <= TRK_MAX_RST;
      end
      else if (apb_wr && paddr == A_CTRL)
         ilv_r <= pwdata[1:0];
      else if (apb_wr && paddr == A_TRKMAX)
         trkmax_r <= pwdata[8:0];
   end

   // Zero-wait slave; read data registered in setup cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b1;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= 1'b1;
         pslverr <= psel & ~penable & (paddr > A_TRKMAX);
         if (apb_rd)
         begin
            if (paddr == A_CTRL)
               prdata <= {30'h0, ilv_r};
            else if (paddr == A_ADDR)
               prdata <= {16'h0, sec_r, trk_r, unit_r, 2'h0} | {28'h0, sub_r};
            else if (paddr == A_LOC)
               prdata <= {20'h0, loc_r};
            else if (paddr == A_STAT)
               prdata <= {28'h0, sub_mode_r, pend_r, seq_en_r, sector_equal};
            else if (paddr == A_TRKMAX)
               prdata <= {23'h0, trkmax_r};
            else
               prdata <= 32'h0000_0000;
         end
      end
   end

   // Checks
   chk_hsr_on_load: assert property (@(posedge pclk) disable iff (!presetn)
      load |=> !head_switch_request_n) else $error("no head switch on load");
   chk_seq_needs_en: assert property (@(posedge pclk) disable iff (!presetn)
      sector_equal |-> $past(seq_en_r)) else $error("equal without enable");
   chk_seq_polarity: assert property (@(posedge pclk) disable iff (!presetn)
      sector_equal != sector_equal_n) else $error("polarity mismatch");
   chk_loc_clear: assert property (@(posedge pclk) disable iff (!presetn)
      sy.origin |=> loc_r == LOC_RST) else $error("location not cleared");
   chk_loc_count: assert property (@(posedge pclk) disable iff (!presetn)
      (sy.ssync_rise && !sy.origin) |=> loc_r == $past(loc_r) + 12'h001)
      else $error("location missed count");
   chk_en_set: assert property (@(posedge pclk) disable iff (!presetn)
      (sy.origin_rise && sy.ready && !ucg_r && !wrap_arm_r) |=> seq_en_r)
      else $error("enable not set");
   chk_en_ready: assert property (@(posedge pclk) disable iff (!presetn)
      !sy.ready |=> !seq_en_r) else $error("enable while not ready");
   chk_sub_step: assert property (@(posedge pclk) disable iff (!presetn)
      (sub_step && !load && !load_subsector_command) |=> sub_r == $past(sub_r) + 4'h1)
      else $error("subsector not stepped");
   chk_trk_load: assert property (@(posedge pclk) disable iff (!presetn)
      load |=> trk_r == $past(host_data_bit[10:4])) else $error("track load");
   chk_track_line: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 track_addr_line[6:0] == $past(trk_r)) else $error("track line stale");

   cov_match: cover property (@(posedge pclk) disable iff (!presetn) sector_equal);
   cov_trk_step: cover property (@(posedge pclk) disable iff (!presetn) trk_step);
   cov_unit_step: cover property (@(posedge pclk) disable iff (!presetn) unit_step);
   cov_done: cover property (@(posedge pclk) disable iff (!presetn) xfer_done);
endmodule

/* tb/dsam_drive_model.sv */
// Behavioural disc drive: revolution origin, subsector sync, ready.
// Assumes the bench calls its tasks from a process aligned to pclk.
`timescale 1ns/1ns
module dsam_drive_model
(
   // Clock
   input  wire logic pclk,
   // Drive outputs
   output      logic track_origin,
   output      logic subsector_sync_n,
   output      logic disc_ready
);
   initial
   begin
      track_origin     = 1'b0;
      subsector_sync_n = 1'b1;
      disc_ready       = 1'b1;
   end

   // Origin high long enough to pass the two-flop synchroniser
   task automatic origin_pulse();
      track_origin <= 1'b1;
      repeat (6) @(posedge pclk);
      track_origin <= 1'b0;
      repeat (6) @(posedge pclk);
   endtask

   // Rising edge of each low pulse marks one subsector
   task automatic sync_pulses(input int n);
      repeat (n)
      begin
         subsector_sync_n <= 1'b0;
         repeat (3) @(posedge pclk);
         subsector_sync_n <= 1'b1;
         repeat (4) @(posedge pclk);
      end
   endtask

   task automatic set_ready(input logic r);
      disc_ready <= r;
      repeat (6) @(posedge pclk);
   endtask
endmodule

/* tb/dsam_top_tb.sv */
// Self-checking bench for the sector address match block.
// Assumes the drive model on the drive pins and an APB master here.
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin err_count++; \
   $display("CHECK FAILED %s exp %0h got %0h", nm, exp, got); end end
module dsam_top_tb;
   import dsam_pkg::*;
   typedef struct { logic [15:0] d; logic [1:0] sh; logic [11:0] loc; } dsam_row_type;

   logic                 pclk = 1'b0;
   logic                 presetn, psel, penable, pwrite;
   logic [11:0]          paddr;
   logic [31:0]          pwdata, prdata, rv;
   logic                 pready, pslverr, re;
   logic                 address_output_strobe, load_subsector_command, parity_cycle_flag;
   logic [HDATA_W-1:0]   host_data_bit;
   wire logic            track_origin, subsector_sync_n, disc_ready;
   logic [TRKLINE_W-1:0] track_addr_line;
   logic [UNIT_W-1:0]    unit_addr;
   logic                 head_switch_request_n, sector_equal, sector_equal_n, xfer_done;
   int                   err_count = 0;
   int                   checks = 0;
   int                   hsr_lows = 0;
   int                   done_cnt = 0;
   dsam_row_type         rows [4];

   always #(CLK_PERIOD_NS / 2) pclk = ~pclk;

   // Pulse counters, so one-cycle outputs are never missed
   always @(posedge pclk)
   begin
      if (head_switch_request_n === 1'b0)
         hsr_lows++;
      if (xfer_done === 1'b1)
         done_cnt++;
   end

   dsam_drive_model dsam_drive_model_inst (
      .pclk(pclk), .track_origin(track_origin),
      .subsector_sync_n(subsector_sync_n), .disc_ready(disc_ready));

   dsam_top dsam_top_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .address_output_strobe(address_output_strobe),
      .load_subsector_command(load_subsector_command), .host_data_bit(host_data_bit),
      .parity_cycle_flag(parity_cycle_flag), .track_origin(track_origin),
      .subsector_sync_n(subsector_sync_n), .disc_ready(disc_ready),
      .track_addr_line(track_addr_line), .unit_addr(unit_addr),
      .head_switch_request_n(head_switch_request_n), .sector_equal(sector_equal),
      .sector_equal_n(sector_equal_n), .xfer_done(xfer_done));

   task automatic print_verdict();
      if (err_count == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Request held until pready is sampled high; one idle cycle after
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rv = prdata;
      re = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic host_load(input logic sub, input logic [15:0] d);
      if (sub)
         load_subsector_command <= 1'b1;
      else
         address_output_strobe <= 1'b1;
      host_data_bit <= d;
      @(posedge pclk);
      load_subsector_command <= 1'b0;
      address_output_strobe  <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic parity_step();
      parity_cycle_flag <= 1'b1;
      @(posedge pclk);
      parity_cycle_flag <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask

   initial
   begin
      repeat (60000) @(posedge pclk);
      err_count++;
      print_verdict();
   end

   initial
   begin
      dsam_row_type r;
      logic         en;
      logic [1:0]   pu;
      int           c0;
      {presetn, psel, penable, pwrite, address_output_strobe} = '0;
      {load_subsector_command, parity_cycle_flag, paddr, pwdata, host_data_bit} = '0;
      en = 1'b0;
      pu = 2'b00;
      rows = '{'{16'h0850, 2'd0, 12'h010}, '{16'h1400, 2'd1, 12'h040},
               '{16'h1AA4, 2'd2, 12'h0C0}, '{16'h0FEC, 2'd3, 12'h080}};
      repeat (20) @(posedge pclk);
      `CHK("hsr_rst", 1'b0, head_switch_request_n)
      `CHK("seq_rst", 1'b0, sector_equal)
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, 12'h010, 32'h0);
      `CHK("trkmax", 32'h0000007F, rv)
      apb(1'b0, 12'h008, 32'h0);
      `CHK("loc_rst", 32'h0, rv)
      for (int i = 0; i < 4; i++)
      begin
         r = rows[i];
         apb(1'b1, 12'h000, {30'h0, r.sh});
         host_load(1'b0, r.d);
         `CHK("hsr_load", 1'b0, head_switch_request_n)
         @(posedge pclk);
         `CHK("trk_line", {2'b00, r.d[10:4]}, track_addr_line)
         `CHK("unit", r.d[3:2], unit_addr)
         apb(1'b0, 12'h004, 32'h0);
         `CHK("addr", {16'h0, r.d & 16'hFFFC}, rv)
         apb(1'b0, 12'h00C, 32'h0);
         `CHK("en_kept", en && (r.d[3:2] == pu), rv[1])
         dsam_drive_model_inst.origin_pulse();
         dsam_drive_model_inst.sync_pulses(int'(r.loc) - 1);
         repeat (5) @(posedge pclk);
         `CHK("seq_early", 1'b0, sector_equal)
         dsam_drive_model_inst.sync_pulses(1);
         repeat (5) @(posedge pclk);
         `CHK("seq", 1'b1, sector_equal)
         `CHK("seq_n", 1'b0, sector_equal_n)
         apb(1'b0, 12'h008, 32'h0);
         `CHK("loc", r.loc, rv[11:0])
         en = 1'b1;
         pu = r.d[3:2];
      end
      dsam_drive_model_inst.set_ready(1'b0);
      `CHK("seq_nrdy", 1'b0, sector_equal)
      `CHK("seq_n_nrdy", 1'b1, sector_equal_n)
      dsam_drive_model_inst.set_ready(1'b1);
      // Subsector command touches only the low four bits
      host_load(1'b0, 16'h0000);
      host_load(1'b1, 16'hFFF3);
      apb(1'b0, 12'h004, 32'h0);
      `CHK("sub_load", 32'h3, rv)
      parity_step();
      apb(1'b0, 12'h004, 32'h0);
      `CHK("sub_step", 32'h4, rv)
      // Last sector of the track: one transfer, then pending track step
      host_load(1'b0, 16'hF890);
      c0 = done_cnt;
      repeat (15) parity_step();
      `CHK("xfer_early", 0, done_cnt - c0)
      parity_step();
      `CHK("xfer_done", 1, done_cnt - c0)
      apb(1'b0, 12'h004, 32'h0);
      `CHK("cascade", 32'h0090, rv)
      apb(1'b0, 12'h00C, 32'h0);
      `CHK("pend_set", 1'b1, rv[2])
      c0 = hsr_lows;
      dsam_drive_model_inst.origin_pulse();
      `CHK("trk_step", 9'h00A, track_addr_line)
      `CHK("hsr_step", 1, hsr_lows - c0)
      apb(1'b0, 12'h00C, 32'h0);
      `CHK("pend_clr", 1'b0, rv[2])
      // Track at its maximum: unit steps, enable waits a revolution
      apb(1'b1, 12'h010, 32'h0000000A);
      host_load(1'b0, 16'hF8A4);
      repeat (16) parity_step();
      dsam_drive_model_inst.origin_pulse();
      `CHK("unit_step", 2'd2, unit_addr)
      `CHK("trk_zero", 9'h000, track_addr_line)
      apb(1'b0, 12'h00C, 32'h0);
      `CHK("en_wait", 1'b0, rv[1])
      dsam_drive_model_inst.origin_pulse();
      apb(1'b0, 12'h00C, 32'h0);
      `CHK("en_back", 1'b1, rv[1])
      // Track 127 wraps at origin fall and drops the enable
      apb(1'b1, 12'h010, 32'h0000007F);
      host_load(1'b0, 16'h07F8);
      dsam_drive_model_inst.origin_pulse();
      apb(1'b0, 12'h00C, 32'h0);
      `CHK("en_wrap", 1'b0, rv[1])
      apb(1'b0, 12'h014, 32'h0);
      `CHK("slverr", 1'b1, re)
      `CHK("unmapped", 32'h0, rv)
      apb(1'b0, 12'h000, 32'h0);
      `CHK("ctrl", 32'h3, rv)
      `CHK("pready", 1'b1, pready)
      // Second reset in mid-run
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      `CHK("hsr_rst2", 1'b0, head_switch_request_n)
      `CHK("trk_rst2", 9'h000, track_addr_line)
      `CHK("seq_rst2", 1'b0, sector_equal)
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      `CHK("hsr_rel", 1'b1, head_switch_request_n)
      print_verdict();
   end
endmodule
